// File: rtl/leuctl_regs.sv
`timescale 1ns/1ns
`include "leuctl_defines.svh"
// Contract
// - flag-set writes of one raise flags, except bits one and two
// - flag-clear writes of one clear flags, except bits one and two
// - eleven enable bits, reset to zero
// - unfiltered extender catches two-cycle pulses
// - filter on needs two-cycle pulses
// - pulse enable routes through generator/extender
// - four-bit width in low-frequency cycles
// - pulse control busy bit seven while syncing
// - busy bits six to zero per register
// - freeze holds updates, release applies together
// - route location, tx and rx enables
module leuctl_regs
  import leuctl_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic [10:0] i_hw_event,
  input wire logic [6:0] i_async_write,
  input wire logic i_tx_serial,
  input wire logic i_rx_pin,
  output logic o_rx_serial,
  output logic o_tx_pin,
  output logic o_tx_pin_oe,
  output logic [2:0] o_location,
  output logic o_rx_pin_enable,
  output logic o_irq
);
  // ****************************************
  // bus decode
  // ****************************************
  wire wr_ifs = i_wr && i_addr == `LEUCTL_OFF_IFS;
  wire wr_ifc = i_wr && i_addr == `LEUCTL_OFF_IFC;
  wire wr_ien = i_wr && i_addr == `LEUCTL_OFF_IEN;
  wire wr_pulse = i_wr && i_addr == `LEUCTL_OFF_PULSE;
  wire wr_freeze = i_wr && i_addr == `LEUCTL_OFF_FREEZE;
  wire wr_route = i_wr && i_addr == `LEUCTL_OFF_ROUTE;
  logic [10:0] flag_reg, flag_next, ien_reg;
  leuctl_pulse_t pulse_reg, pulse_lf_reg;
  leuctl_route_t route_reg;
  logic freeze_reg;
  logic [7:0] busy_reg, busy_next;
  logic [1:0] sync_cnt_reg;
  // ****************************************
  // interrupt flags
  // ****************************************
  // set wins over clear so no event is lost in a clear cycle
  wire [10:0] sw_set = wr_ifs ? i_wdata[10:0] & `LEUCTL_FLAG_SW_MASK : 11'h000;
  wire [10:0] sw_clr = wr_ifc ? i_wdata[10:0] & `LEUCTL_FLAG_SW_MASK : 11'h000;
  assign flag_next = (flag_reg & ~sw_clr) | sw_set | i_hw_event;
  wire irq_next = |(flag_next & ien_reg) && !wr_ien || wr_ien && |(flag_next & i_wdata[10:0]);
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      flag_reg <= 11'h000;
      ien_reg <= 11'h000;
      o_irq <= 1'b0;
    end
    else
    begin
      flag_reg <= flag_next;
      if (wr_ien)
        ien_reg <= i_wdata[10:0];
      o_irq <= irq_next;
    end
  end
  // ****************************************
  // control registers and sync busy
  // ****************************************
  // busy stays set while frozen; all pending values commit on release
  wire sync_tick = !freeze_reg && sync_cnt_reg == 2'(`LEUCTL_SYNC_CYCLES - 4'h1);
  // a write landing on the commit tick stays pending for the next round
  assign busy_next = (sync_tick ? 8'h00 : busy_reg) | {wr_pulse, i_async_write};
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      pulse_reg <= '0;
      pulse_lf_reg <= '0;
      route_reg <= '0;
      freeze_reg <= 1'b0;
      busy_reg <= 8'h00;
      sync_cnt_reg <= 2'h0;
    end
    else
    begin
      if (wr_pulse)
        pulse_reg <= leuctl_pulse_t'(i_wdata[5:0]);
      if (wr_freeze)
        freeze_reg <= i_wdata[0];
      if (wr_route)
        route_reg <= leuctl_route_t'({i_wdata[10:8], i_wdata[1:0]});
      busy_reg <= busy_next;
      if (freeze_reg || busy_reg == 8'h00)
        sync_cnt_reg <= 2'h0;
      else
        sync_cnt_reg <= sync_cnt_reg + 2'h1;
      if (sync_tick && busy_reg[7])
        pulse_lf_reg <= pulse_reg;
    end
  end
  // ****************************************
  // read mux
  // ****************************************
  wire [31:0] rd_mux =
    i_addr == `LEUCTL_OFF_IF ? {21'h0, flag_reg} :
    i_addr == `LEUCTL_OFF_IEN ? {21'h0, ien_reg} :
    i_addr == `LEUCTL_OFF_PULSE ? {26'h0, pulse_reg} :
    i_addr == `LEUCTL_OFF_FREEZE ? {31'h0, freeze_reg} :
    i_addr == `LEUCTL_OFF_SYNCB ? {24'h0, busy_reg} :
    i_addr == `LEUCTL_OFF_ROUTE ? {21'h0, route_reg.location, 6'h00,
                                    route_reg.tx_pin_enable, route_reg.rx_pin_enable} :
    `LEUCTL_RESET_ZERO;
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      o_rdata <= `LEUCTL_RESET_ZERO;
    else
      o_rdata <= i_rd ? rd_mux : `LEUCTL_RESET_ZERO;
  end
  // ****************************************
  // low-frequency tick and pulse generator
  // ****************************************
  // the low-frequency clock is emulated by a divider tick to stay single-domain
  logic [9:0] lf_div_reg;
  logic [3:0] gen_cnt_reg;
  leuctl_gen_t gen_state_reg;
  logic tx_d_reg, gen_out_reg;
  wire lf_tick = lf_div_reg == 10'(`LEUCTL_LF_DIV - 1);
  wire tx_fall = tx_d_reg && !i_tx_serial;
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      lf_div_reg <= 10'h000;
      gen_state_reg <= LEUCTL_GEN_IDLE;
      gen_cnt_reg <= 4'h0;
      tx_d_reg <= 1'b1;
      gen_out_reg <= 1'b0;
    end
    else
    begin
      lf_div_reg <= lf_tick ? 10'h000 : lf_div_reg + 10'h001;
      tx_d_reg <= i_tx_serial;
      unique case (gen_state_reg)
        LEUCTL_GEN_IDLE:
          if (tx_fall)
            gen_state_reg <= LEUCTL_GEN_WAIT;
        LEUCTL_GEN_WAIT:
          if (lf_tick)
          begin
            gen_state_reg <= LEUCTL_GEN_HIGH;
            gen_out_reg <= 1'b1;
            gen_cnt_reg <= pulse_lf_reg.pulse_width;
          end
        LEUCTL_GEN_HIGH:
          if (lf_tick)
          begin
            if (gen_cnt_reg == 4'h0)
            begin
              gen_out_reg <= 1'b0;
              gen_state_reg <= LEUCTL_GEN_IDLE;
            end
            else
              gen_cnt_reg <= gen_cnt_reg - 4'h1;
          end
        default:
          gen_state_reg <= LEUCTL_GEN_IDLE;
      endcase
    end
  end
  // ****************************************
  // pulse extender and pin routing
  // ****************************************
  logic rx_s1_reg, rx_s2_reg, rx_s3_reg, ext_reg;
  // filter requires two consecutive high samples, costing one cycle of detection
  wire pulse_seen = pulse_lf_reg.pulse_filter_enable ? rx_s2_reg && rx_s3_reg : rx_s2_reg;
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      rx_s1_reg <= 1'b0;
      rx_s2_reg <= 1'b0;
      rx_s3_reg <= 1'b0;
      ext_reg <= 1'b0;
      o_rx_serial <= 1'b1;
      o_tx_pin <= 1'b1;
      o_tx_pin_oe <= 1'b0;
      o_location <= 3'h0;
      o_rx_pin_enable <= 1'b0;
    end
    else
    begin
      rx_s1_reg <= i_rx_pin;
      rx_s2_reg <= rx_s1_reg;
      rx_s3_reg <= rx_s2_reg;
      if (pulse_seen)
        ext_reg <= 1'b1;
      else if (lf_tick)
        ext_reg <= 1'b0;
      o_rx_serial <= !route_reg.rx_pin_enable ? 1'b1 :
                     pulse_lf_reg.pulse_path_enable ? !ext_reg : rx_s2_reg;
      o_tx_pin <= pulse_lf_reg.pulse_path_enable ? gen_out_reg : i_tx_serial;
      o_tx_pin_oe <= route_reg.tx_pin_enable;
      o_location <= route_reg.location;
      o_rx_pin_enable <= route_reg.rx_pin_enable;
    end
  end
  // ****************************************
  // checks
  // ****************************************
  irq_follows_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    ##1 o_irq == |($past(flag_next) & ien_reg))
    else $error("irq mismatch");
  flag_set_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    wr_ifs && i_wdata[0] |=> flag_reg[0])
    else $error("set lost");
  flag_clr_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    wr_ifc && i_wdata[0] && !i_hw_event[0] && !wr_ifs |=> !flag_reg[0])
    else $error("clear lost");
  ien_write_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    wr_ien |=> ien_reg == $past(i_wdata[10:0]))
    else $error("enable write");
  busy_pulse_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    wr_pulse |=> busy_reg[7])
    else $error("busy not set");
  busy_other_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_async_write[0] |=> busy_reg[0])
    else $error("busy bit");
  freeze_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    freeze_reg |=> $stable(pulse_lf_reg))
    else $error("frozen update");
  route_oe_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    wr_route |=> ##1 o_tx_pin_oe == $past(i_wdata[1], 2))
    else $error("route oe");
  bypass_tx_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !pulse_lf_reg.pulse_path_enable |=> o_tx_pin == $past(i_tx_serial))
    else $error("bypass tx");
  rdata_idle_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data not idle");
  rd_busy_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    i_rd && i_addr == `LEUCTL_OFF_SYNCB |=> o_rdata == {24'h00_0000, $past(busy_reg)})
    else $error("busy read");
  flag_rsvd_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    wr_ifs && !i_hw_event[1] && !flag_reg[1] |=> !flag_reg[1])
    else $error("reserved set bit");
  set_wins_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    wr_ifc && i_hw_event[0] |=> flag_reg[0])
    else $error("event lost on clear");
  flag_keep_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !wr_ifc && !wr_ifs && i_hw_event == 11'h000 |=> $stable(flag_reg))
    else $error("flags moved");
  ien_keep_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !wr_ien |=> $stable(ien_reg))
    else $error("enable moved");
  pulse_keep_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !wr_pulse |=> $stable(pulse_reg))
    else $error("pulse control moved");
  route_keep_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !wr_route |=> $stable(route_reg))
    else $error("route moved");
  freeze_wr_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    wr_freeze |=> freeze_reg == $past(i_wdata[0]))
    else $error("freeze write");
  freeze_busy_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    freeze_reg && busy_reg[7] |=> busy_reg[7])
    else $error("busy cleared while frozen");
  commit_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    sync_tick && busy_reg[7] |=> pulse_lf_reg == $past(pulse_reg))
    else $error("pulse commit");
  ext_set_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    pulse_seen |=> ext_reg)
    else $error("pulse missed");
  ext_drop_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    ext_reg && lf_tick && !pulse_seen |=> !ext_reg)
    else $error("extend stuck");
  filt_block_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    pulse_lf_reg.pulse_filter_enable && !rx_s3_reg && !ext_reg |=> !ext_reg)
    else $error("filter passed short pulse");
  gen_width_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    gen_state_reg == LEUCTL_GEN_WAIT && lf_tick |=>
      gen_cnt_reg == $past(pulse_lf_reg.pulse_width))
    else $error("pulse width load");
  gen_end_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    gen_state_reg == LEUCTL_GEN_HIGH && lf_tick && gen_cnt_reg == 4'h0 |=> !gen_out_reg)
    else $error("pulse end");
  ir_tx_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    pulse_lf_reg.pulse_path_enable |=> o_tx_pin == $past(gen_out_reg))
    else $error("generator path");
  ir_rx_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    route_reg.rx_pin_enable && pulse_lf_reg.pulse_path_enable |=>
      o_rx_serial == !$past(ext_reg))
    else $error("extender path");
  rx_off_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !route_reg.rx_pin_enable |=> o_rx_serial)
    else $error("rx not idle");
  loc_follow_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    wr_route |=> ##1 o_location == $past(i_wdata[10:8], 2))
    else $error("location");
endmodule : leuctl_regs

// File: shared/leuctl_defines.svh
`ifndef LEUCTL_DEFINES_SVH
`define LEUCTL_DEFINES_SVH
// ****************************************
// register offsets
// ****************************************
`define LEUCTL_OFF_IFS 8'h30
`define LEUCTL_OFF_IFC 8'h34
`define LEUCTL_OFF_IEN 8'h38
`define LEUCTL_OFF_PULSE 8'h3c
`define LEUCTL_OFF_FREEZE 8'h40
`define LEUCTL_OFF_SYNCB 8'h44
`define LEUCTL_OFF_ROUTE 8'h54
`define LEUCTL_OFF_IF 8'h2c
// ****************************************
// field layout and reset values
// ****************************************
`define LEUCTL_FLAG_W 11
`define LEUCTL_FLAG_SW_MASK 11'h7f9
`define LEUCTL_BUSY_W 8
`define LEUCTL_PULSE_FILT_BIT 5
`define LEUCTL_PULSE_EN_BIT 4
`define LEUCTL_LOC_MAX 3'h4
`define LEUCTL_RESET_ZERO 32'h0
// ****************************************
// timing
// ****************************************
`define LEUCTL_CLK_SYS_HZ 20000000
`define LEUCTL_LF_CLK_HZ 32768
`define LEUCTL_LF_DIV (`LEUCTL_CLK_SYS_HZ / `LEUCTL_LF_CLK_HZ)
`define LEUCTL_SYNC_CYCLES 4'h3
`endif

// File: shared/leuctl_pkg.sv
package leuctl_pkg;
  typedef struct packed {
    logic pulse_filter_enable;
    logic pulse_path_enable;
    logic [3:0] pulse_width;
  } leuctl_pulse_t;
  typedef struct packed {
    logic [2:0] location;
    logic tx_pin_enable;
    logic rx_pin_enable;
  } leuctl_route_t;
  typedef enum logic [1:0] {
    LEUCTL_GEN_IDLE = 2'b00,
    LEUCTL_GEN_HIGH = 2'b01,
    LEUCTL_GEN_WAIT = 2'b10
  } leuctl_gen_t;
endpackage : leuctl_pkg

// File: verif/leuctl_ir_partner.sv
`timescale 1ns/1ns
// ****
// remote infrared transceiver
// ****
module leuctl_ir_partner
(
  input wire logic i_clk_sys,
  input wire logic i_ir_mode,
  output logic o_rx_pin
);
  logic pulse_on;
  // a plain line idles high, an ir line idles dark
  assign o_rx_pin = pulse_on ? i_ir_mode : ~i_ir_mode;
  initial pulse_on = 1'b0;
  task automatic send_pulse(input int cycles);
  begin
    @(posedge i_clk_sys);
    pulse_on <= 1'b1;
    repeat (cycles) @(posedge i_clk_sys);
    pulse_on <= 1'b0;
  end
  endtask : send_pulse
endmodule : leuctl_ir_partner

// File: verif/leuctl_regs_tb_top.sv
`timescale 1ns/1ns
`include "leuctl_defines.svh"
// ****
// testbench
// ****
module leuctl_regs_tb_top;
  logic clk, rst, wr, rd, txs, irm, rxs, txp, oe, rxe, irq, rxp;
  logic [7:0] addr;
  logic [31:0] wd, rdv, rv;
  logic [10:0] ev;
  logic [6:0] aw;
  logic [2:0] loc;
  logic [7:0] offs [6];
  int fails = 0;
  int check_count = 0;
  int n, h;
  leuctl_regs leuctl_regs_inst (.i_clk_sys(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wd),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdv), .i_hw_event(ev), .i_async_write(aw),
    .i_tx_serial(txs), .i_rx_pin(rxp), .o_rx_serial(rxs), .o_tx_pin(txp), .o_tx_pin_oe(oe),
    .o_location(loc), .o_rx_pin_enable(rxe), .o_irq(irq));
  leuctl_ir_partner leuctl_ir_partner_inst (.i_clk_sys(clk), .i_ir_mode(irm), .o_rx_pin(rxp));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
  begin
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
  begin
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  end
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a);
  begin
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    // read data stand for one cycle; take them at the edge that closes it
    @(posedge clk);
    rv = rdv;
  end
  endtask : rd_reg
  // software waits for the busy bits before touching the register again
  task automatic poll(input logic [31:0] m);
  begin
    n = 0;
    do
    begin
      rd_reg(`LEUCTL_OFF_SYNCB);
      n++;
    end
    while ((rv & m) != 32'h0 && n < 1500);
    chk(rv & m, 32'h0);
  end
  endtask : poll
  task automatic wait_sig(input logic t, input logic v, input int lim);
  begin
    n = 0;
    while (((t ? txp : rxs) !== v) && n < lim)
    begin
      @(posedge clk);
      n++;
    end
  end
  endtask : wait_sig
  task automatic report_and_stop;
  begin
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask : report_and_stop
  // run should need about 4300 cycles
  initial
  begin
    #(50 * 40000);
    fails++;
    report_and_stop();
  end
  initial
  begin
    rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h0; wd = 32'h0;
    ev = 11'h0; aw = 7'h0; txs = 1'b1; irm = 1'b0;
    offs = '{`LEUCTL_OFF_IF, `LEUCTL_OFF_IEN, `LEUCTL_OFF_PULSE, `LEUCTL_OFF_FREEZE,
      `LEUCTL_OFF_SYNCB, `LEUCTL_OFF_ROUTE};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      rd_reg(offs[i]);
      chk(rv, `LEUCTL_RESET_ZERO);
    end
    $display("test reset done");
    wr_reg(`LEUCTL_OFF_IEN, 32'hffffffff);
    rd_reg(`LEUCTL_OFF_IEN);
    chk(rv, 32'h7ff);
    wr_reg(`LEUCTL_OFF_IFS, 32'hffffffff);
    rd_reg(`LEUCTL_OFF_IF);
    chk(rv, 32'h7f9);
    chk(irq, 1'b1);
    wr_reg(`LEUCTL_OFF_IFC, 32'h1);
    wr_reg(`LEUCTL_OFF_IFS, 32'h0);
    rd_reg(`LEUCTL_OFF_IF);
    chk(rv, 32'h7f8);
    wr_reg(`LEUCTL_OFF_IEN, 32'h4);
    wr_reg(`LEUCTL_OFF_IFC, 32'hffffffff);
    rd_reg(`LEUCTL_OFF_IF);
    chk({rv[10:0], irq}, 12'h0);
    @(posedge clk);
    ev <= 11'h004;
    @(posedge clk);
    ev <= 11'h0;
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    $display("test flags done");
    wr_reg(`LEUCTL_OFF_ROUTE, 32'hfffff403);
    rd_reg(`LEUCTL_OFF_ROUTE);
    chk(rv, 32'h403);
    chk({loc, oe, rxe}, 5'b10011);
    @(posedge clk);
    aw <= 7'h7f;
    @(posedge clk);
    aw <= 7'h0;
    rd_reg(`LEUCTL_OFF_SYNCB);
    chk(rv, 32'h7f);
    poll(32'h7f);
    $display("test route and busy done");
    txs <= 1'b0;
    wait_sig(1'b1, 1'b0, 20);
    chk(txp, 1'b0);
    txs <= 1'b1;
    fork
      leuctl_ir_partner_inst.send_pulse(30);
      wait_sig(1'b0, 1'b0, 20);
    join
    chk(rxs, 1'b0);
    wr_reg(`LEUCTL_OFF_FREEZE, 32'h1);
    wr_reg(`LEUCTL_OFF_PULSE, 32'h32);
    rd_reg(`LEUCTL_OFF_SYNCB);
    chk(rv, 32'h80);
    repeat (1300) @(posedge clk);
    rd_reg(`LEUCTL_OFF_SYNCB);
    chk(rv, 32'h80);
    wr_reg(`LEUCTL_OFF_FREEZE, 32'h0);
    poll(32'h80);
    $display("test freeze done");
    irm <= 1'b1;
    wait_sig(1'b0, 1'b1, 1300);
    fork
      leuctl_ir_partner_inst.send_pulse(3);
      wait_sig(1'b0, 1'b0, 30);
    join
    chk(rxs, 1'b0);
    txs <= 1'b0;
    wait_sig(1'b1, 1'b1, 1300);
    h = 0;
    while (txp === 1'b1 && h < 3000)
    begin
      @(posedge clk);
      h++;
    end
    // generated pulse lasts width plus one low-frequency ticks
    chk(h > 3 * `LEUCTL_LF_DIV - 3 && h < 3 * `LEUCTL_LF_DIV + 3, 1'b1);
    txs <= 1'b1;
    wr_reg(`LEUCTL_OFF_PULSE, 32'h10);
    poll(32'h80);
    wait_sig(1'b0, 1'b1, 1300);
    fork
      leuctl_ir_partner_inst.send_pulse(2);
      wait_sig(1'b0, 1'b0, 30);
    join
    chk(rxs, 1'b0);
    $display("test pulse done");
    report_and_stop();
  end
endmodule : leuctl_regs_tb_top
